/* File: logic/ubep_bulk_endpoints.sv */
// Bulk/interrupt endpoint handshake logic: answers IN/OUT tokens, keeps toggles.
// Assumes a serial engine on mclk_i delivering decoded, CRC-checked events.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
`include "ubep_consts.svh"
module ubep_bulk_endpoints (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic usb_reset_i,
    input wire logic [`UBEP_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire ubep_pkg::ubep_link_s link_i,
    output ubep_pkg::ubep_resp_s resp_o,
    output logic irq_o
);
    ubep_pkg::ubep_state_s st;
    ubep_pkg::ubep_state_s next_st;

    // Pair partner: bit 0 joins IN 2/3, bit 1 joins 4/5 (same bits for OUT)
    function automatic logic [2:0] partner(input logic [2:0] ep);
        partner = {ep[2:1], ~ep[0]};
    endfunction

    function automatic logic is_paired(input logic [7:0] pr, input logic [2:0] ep);
        is_paired = (ep[2:1] == 2'd1 && pr[0]) || (ep[2:1] == 2'd2 && pr[1]);
    endfunction

    logic [2:0] wep;
    logic [2:0] lep;
    logic lpair;
    logic [2:0] phy;
    logic [5:0] in_busy_view;
    logic [5:0] out_busy_view;

    assign wep = addr_i[2:0];
    assign lep = link_i.ep;
    assign lpair = is_paired(st.pairing, lep);

    // Busy as firmware sees it; paired view merges both halves
    genvar g;
    generate
        for (g = 0; g < `UBEP_NUM_EP; g++) begin : g_busy
            localparam logic [2:0] GEP = 3'(g);
            assign in_busy_view[g] = is_paired(st.pairing, GEP) ?
                (st.in_arm[g] & st.in_arm[partner(GEP)]) : st.in_arm[g];
            assign out_busy_view[g] = is_paired(st.pairing, GEP) ?
                (st.out_arm[g] & st.out_arm[partner(GEP)]) : st.out_arm[g];
        end
    endgenerate

    // Paired IN: send from whichever half is armed; tokens to the even endpoint try the side pointer first, tokens to the odd one the even half
    always_comb begin
        phy = lep;
        if (lpair) begin
            phy = st.in_side[lep] ? partner(lep) : {lep[2:1], 1'b0};
            if (!st.in_arm[phy]) begin
                phy = partner(phy);
            end
        end
    end

    logic [2:0] ophy;
    always_comb begin
        ophy = lep;
        if (lpair) begin
            ophy = st.out_side[lep] ? partner(lep) : {lep[2:1], 1'b0};
            if (!st.out_arm[ophy]) begin
                ophy = partner(ophy);
            end
        end
    end

    // Paired IN halves report and toggle through the even endpoint; paired OUT uses the token's endpoint
    logic [2:0] ack_ep;
    assign ack_ep = {st.cur_ep[2:1], 1'b0}
        | 3'(!is_paired(st.pairing, st.cur_ep) & st.cur_ep[0]);

    logic ep_ok_in;
    logic ep_ok_out;
    assign ep_ok_in = (lep != 3'd0) && (lep < 3'(`UBEP_NUM_EP)) && st.in_valid[lep];
    assign ep_ok_out = (lep != 3'd0) && (lep < 3'(`UBEP_NUM_EP)) && st.out_valid[lep];

    always_comb begin
        next_st = st;
        next_st.resp = '0;
        next_st.rdata = 8'h00;
        // Any new token drops a pending ACK wait, even a refused one
        if (link_i.in_token || link_i.out_done) begin
            next_st.phase = ubep_pkg::UBEP_IDLE;
        end
        // Host side events; errors give no answer at all
        if (link_i.in_token && !link_i.bad && ep_ok_in) begin
            next_st.resp.send = 1'b1;
            next_st.resp.ep = lep;
            if (st.in_stall[lep]) begin
                next_st.resp.pid = `UBEP_PID_STALL;
            end else if (st.in_arm[phy]) begin
                next_st.resp.pid = st.in_tog[lep] ? `UBEP_PID_DATA1 : `UBEP_PID_DATA0;
                next_st.resp.count = st.in_bc[phy];
                next_st.resp.ep = phy;
                next_st.resp.buf_sel = phy[0];
                next_st.phase = ubep_pkg::UBEP_IN_WAIT_ACK;
                next_st.cur_ep = phy;
            end else begin
                next_st.resp.pid = `UBEP_PID_NAK;
            end
        end else if (link_i.out_done && !link_i.bad && ep_ok_out) begin
            next_st.resp.send = 1'b1;
            next_st.resp.ep = ophy;
            next_st.resp.buf_sel = ophy[0];
            if (st.out_stall[lep]) begin
                next_st.resp.pid = `UBEP_PID_STALL;
            end else if (st.out_arm[ophy]) begin
                next_st.resp.pid = `UBEP_PID_ACK;
                next_st.out_arm[ophy] = 1'b0;
                next_st.out_irq[lep] = 1'b1;
                next_st.out_tog[lep] = ~st.out_tog[lep];
                if (lpair) begin
                    next_st.out_side[lep] = ~ophy[0];
                end
            end else begin
                next_st.resp.pid = `UBEP_PID_NAK;
            end
        end else if (link_i.host_ack && st.phase == ubep_pkg::UBEP_IN_WAIT_ACK) begin
            next_st.phase = ubep_pkg::UBEP_IDLE;
            next_st.in_arm[st.cur_ep] = 1'b0;
            next_st.in_irq[ack_ep] = 1'b1;
            next_st.in_tog[ack_ep] = ~st.in_tog[ack_ep];
            if (is_paired(st.pairing, st.cur_ep)) begin
                next_st.in_side[{st.cur_ep[2:1], 1'b0}] = ~st.cur_ep[0];
            end
        end

        // Firmware writes; a hardware IRQ set in the same cycle is kept
        if (wr_i) begin
            unique case (addr_i)
                `UBEP_ADR_IN_VALID: next_st.in_valid = wdata_i;
                `UBEP_ADR_OUT_VALID: next_st.out_valid = wdata_i;
                `UBEP_ADR_PAIRING: next_st.pairing = wdata_i;
                `UBEP_ADR_IN_IEN: next_st.in_ien = wdata_i;
                `UBEP_ADR_OUT_IEN: next_st.out_ien = wdata_i;
                `UBEP_ADR_IN_IRQ: next_st.in_irq = st.in_irq & ~wdata_i[5:0]
                    | (next_st.in_irq & ~st.in_irq);
                `UBEP_ADR_OUT_IRQ: next_st.out_irq = st.out_irq & ~wdata_i[5:0]
                    | (next_st.out_irq & ~st.out_irq);
                `UBEP_ADR_TOGGLE: begin
                    next_st.toggle_sel = wdata_i;
                    if (wdata_i[`UBEP_TOG_SET] ^ wdata_i[`UBEP_TOG_CLR]) begin
                        if (wdata_i[`UBEP_TOG_DIR]) begin
                            next_st.in_tog[wdata_i[2:0]] = wdata_i[`UBEP_TOG_SET];
                        end else begin
                            next_st.out_tog[wdata_i[2:0]] = wdata_i[`UBEP_TOG_SET];
                        end
                    end
                end
                default: begin
                    if (addr_i[5:3] == 3'd2 && wep < 3'(`UBEP_NUM_EP)) begin
                        // Paired IN loads go to the partner half whenever the addressed half is armed
                        if (is_paired(st.pairing, wep) && st.in_arm[wep]) begin
                            next_st.in_bc[partner(wep)] = wdata_i;
                            next_st.in_arm[partner(wep)] = 1'b1;
                        end else begin
                            next_st.in_bc[wep] = wdata_i;
                            next_st.in_arm[wep] = 1'b1;
                        end
                    end else if (addr_i[5:3] == 3'd4 && wep < 3'(`UBEP_NUM_EP)) begin
                        if (is_paired(st.pairing, wep) && st.out_arm[wep]) begin
                            next_st.out_bc[partner(wep)] = wdata_i;
                            next_st.out_arm[partner(wep)] = 1'b1;
                        end else begin
                            next_st.out_bc[wep] = wdata_i;
                            next_st.out_arm[wep] = 1'b1;
                        end
                    end else if (addr_i[5:3] == 3'd3 && wep < 3'(`UBEP_NUM_EP)) begin
                        next_st.in_stall[wep] = wdata_i[`UBEP_CS_STALL];
                        if (wdata_i[`UBEP_CS_BUSY] && is_paired(st.pairing, wep)) begin
                            next_st.in_arm[wep] = 1'b0;
                            next_st.in_arm[partner(wep)] = 1'b0;
                        end
                    end else if (addr_i[5:3] == 3'd5 && wep < 3'(`UBEP_NUM_EP)) begin
                        next_st.out_stall[wep] = wdata_i[`UBEP_CS_STALL];
                        if (wdata_i[`UBEP_CS_BUSY] && is_paired(st.pairing, wep)) begin
                            next_st.out_arm[wep] = 1'b0;
                            next_st.out_arm[partner(wep)] = 1'b0;
                        end
                    end
                end
            endcase
        end

        // Read data appear in the next cycle only
        if (rd_i) begin
            if (addr_i == `UBEP_ADR_IN_VALID) next_st.rdata = st.in_valid;
            else if (addr_i == `UBEP_ADR_OUT_VALID) next_st.rdata = st.out_valid;
            else if (addr_i == `UBEP_ADR_PAIRING) next_st.rdata = st.pairing;
            else if (addr_i == `UBEP_ADR_IN_IEN) next_st.rdata = st.in_ien;
            else if (addr_i == `UBEP_ADR_OUT_IEN) next_st.rdata = st.out_ien;
            else if (addr_i == `UBEP_ADR_IN_IRQ) next_st.rdata = {2'b00, st.in_irq};
            else if (addr_i == `UBEP_ADR_OUT_IRQ) next_st.rdata = {2'b00, st.out_irq};
            else if (addr_i == `UBEP_ADR_TOGGLE) next_st.rdata = st.toggle_sel;
            else if (addr_i == `UBEP_ADR_TOG_STATE) begin
                next_st.rdata = {7'd0, st.toggle_sel[`UBEP_TOG_DIR] ?
                    st.in_tog[st.toggle_sel[2:0]] : st.out_tog[st.toggle_sel[2:0]]};
            end else if (wep < 3'(`UBEP_NUM_EP)) begin
                if (addr_i[5:3] == 3'd2) next_st.rdata = st.in_bc[wep];
                else if (addr_i[5:3] == 3'd4) next_st.rdata = st.out_bc[wep];
                else if (addr_i[5:3] == 3'd3)
                    next_st.rdata = {6'd0, in_busy_view[wep], st.in_stall[wep]};
                else if (addr_i[5:3] == 3'd5)
                    next_st.rdata = {6'd0, out_busy_view[wep], st.out_stall[wep]};
            end
        end

        next_st.irq = |(next_st.in_irq & st.in_ien[5:0])
            | |(next_st.out_irq & st.out_ien[5:0]);

        // Bus reset returns endpoints to unarmed, toggles to DATA0
        if (usb_reset_i) begin
            next_st.in_arm = '0;
            next_st.out_arm = '0;
            next_st.in_tog = '0;
            next_st.out_tog = '0;
            next_st.phase = ubep_pkg::UBEP_IDLE;
            next_st.resp = '0;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign resp_o = st.resp;
    assign irq_o = st.irq;

    a_in_stall_wins: assert property (@(posedge mclk_i) disable iff (reset_i || usb_reset_i)
        link_i.in_token && !link_i.bad && ep_ok_in && st.in_stall[lep]
        |=> resp_o.send && resp_o.pid == `UBEP_PID_STALL) else $error("IN stall missed");
    a_bad_silent: assert property (@(posedge mclk_i) disable iff (reset_i)
        link_i.bad |=> !resp_o.send) else $error("Answer after error");
    a_in_data_count: assert property (@(posedge mclk_i) disable iff (reset_i || usb_reset_i)
        link_i.in_token && !link_i.bad && ep_ok_in && !st.in_stall[lep] && !lpair
        && st.in_arm[lep] |=> resp_o.count == $past(st.in_bc[lep])
        && resp_o.pid != `UBEP_PID_NAK) else $error("IN count wrong");
    a_in_nak: assert property (@(posedge mclk_i) disable iff (reset_i || usb_reset_i)
        link_i.in_token && !link_i.bad && ep_ok_in && !st.in_stall[lep] && !lpair
        && !st.in_arm[lep] |=> resp_o.pid == `UBEP_PID_NAK) else $error("IN NAK missed");
    a_out_ack_irq: assert property (@(posedge mclk_i) disable iff (reset_i || usb_reset_i)
        link_i.out_done && !link_i.bad && ep_ok_out && !st.out_stall[lep] && !lpair
        && st.out_arm[lep] |=> resp_o.pid == `UBEP_PID_ACK && st.out_irq[$past(lep)]
        && !st.out_arm[$past(lep)]) else $error("OUT ACK wrong");
    a_out_nak: assert property (@(posedge mclk_i) disable iff (reset_i || usb_reset_i)
        link_i.out_done && !link_i.bad && ep_ok_out && !st.out_stall[lep] && !lpair
        && !st.out_arm[lep] |=> resp_o.pid == `UBEP_PID_NAK) else $error("OUT NAK missed");
    a_out_stall: assert property (@(posedge mclk_i) disable iff (reset_i || usb_reset_i)
        link_i.out_done && !link_i.bad && ep_ok_out && st.out_stall[lep]
        |=> resp_o.pid == `UBEP_PID_STALL) else $error("OUT stall missed");
    a_bc_arms: assert property (@(posedge mclk_i) disable iff (reset_i || usb_reset_i)
        wr_i && addr_i[5:3] == 3'd4 && wep != 3'd0 && wep < 3'd6
        && !is_paired(st.pairing, wep) |=> st.out_arm[$past(wep)]) else $error("OUT not armed");
    a_tog_flip: assert property (@(posedge mclk_i) disable iff (reset_i || usb_reset_i)
        link_i.out_done && !link_i.bad && ep_ok_out && !st.out_stall[lep]
        && st.out_arm[ophy] && !wr_i |=> st.out_tog[$past(lep)] != $past(st.out_tog[lep]))
        else $error("Toggle not flipped");
    a_irq_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
        (st.in_irq & st.in_ien[5:0]) == 6'd0 && (st.out_irq & st.out_ien[5:0]) == 6'd0
        && $stable(st.in_irq) && $stable(st.out_irq) && $stable(st.in_ien)
        && $stable(st.out_ien) |-> !irq_o) else $error("Interrupt not gated");
endmodule

/* File: logic/ubep_consts.svh */
// Offsets, field positions and reset values of the bulk endpoint handshake block.
// Assumes the including file is compiled after nothing else defines these names.
`ifndef UBEP_CONSTS_SVH
`define UBEP_CONSTS_SVH
`define UBEP_ADDR_W 6
`define UBEP_ADR_IN_VALID 6'h00
`define UBEP_ADR_OUT_VALID 6'h01
`define UBEP_ADR_PAIRING 6'h02
`define UBEP_ADR_IN_IEN 6'h03
`define UBEP_ADR_OUT_IEN 6'h04
`define UBEP_ADR_IN_IRQ 6'h05
`define UBEP_ADR_OUT_IRQ 6'h06
`define UBEP_ADR_TOGGLE 6'h07
`define UBEP_ADR_TOG_STATE 6'h08
`define UBEP_ADR_IN_BC 6'h10
`define UBEP_ADR_IN_CS 6'h18
`define UBEP_ADR_OUT_BC 6'h20
`define UBEP_ADR_OUT_CS 6'h28
`define UBEP_NUM_EP 6
`define UBEP_CS_STALL 0
`define UBEP_CS_BUSY 1
`define UBEP_TOG_EP_MSB 2
`define UBEP_TOG_DIR 4
`define UBEP_TOG_CLR 5
`define UBEP_TOG_SET 6
`define UBEP_VALID_RESET 8'h00
`define UBEP_PID_DATA0 4'h3
`define UBEP_PID_DATA1 4'hB
`define UBEP_PID_ACK 4'h2
`define UBEP_PID_NAK 4'hA
`define UBEP_PID_STALL 4'hE
`endif

/* File: logic/ubep_pkg.sv */
// Types shared by the bulk endpoint handshake block.
// Assumes the link layer decodes tokens and CRC before this block.
package ubep_pkg;
    typedef enum logic [1:0] {
        UBEP_IDLE,
        UBEP_IN_WAIT_ACK
    } ubep_phase_e;

    // One decoded event from the serial engine
    typedef struct packed {
        logic in_token;
        logic out_done;
        logic host_ack;
        logic bad;
        logic [2:0] ep;
    } ubep_link_s;

    // Answer toward the serial engine
    typedef struct packed {
        logic send;
        logic [3:0] pid;
        logic [7:0] count;
        logic [2:0] ep;
        logic buf_sel;
    } ubep_resp_s;

    typedef struct packed {
        logic [7:0] in_valid;
        logic [7:0] out_valid;
        logic [7:0] pairing;
        logic [7:0] in_ien;
        logic [7:0] out_ien;
        logic [5:0] in_irq;
        logic [5:0] out_irq;
        logic [7:0] toggle_sel;
        logic [5:0] in_tog;
        logic [5:0] out_tog;
        logic [5:0] in_stall;
        logic [5:0] out_stall;
        logic [5:0][7:0] in_bc;
        logic [5:0][7:0] out_bc;
        logic [5:0] in_arm;
        logic [5:0] out_arm;
        logic [5:0] in_side;
        logic [5:0] out_side;
        ubep_phase_e phase;
        logic [2:0] cur_ep;
        logic [7:0] rdata;
        ubep_resp_s resp;
        logic irq;
    } ubep_state_s;
endpackage

/* File: tb/ubep_host_model.sv */
// Host side of the link: turns bench commands into token events, acks data.
// Assumes the bench raises go_i for one cycle and waits for the answer.
`timescale 1ns/10ps
`include "ubep_consts.svh"
module ubep_host_model (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic go_i,
    input wire logic out_i,
    input wire logic bad_i,
    input wire logic ack_en_i,
    input wire logic [2:0] ep_i,
    input wire ubep_pkg::ubep_resp_s resp_i,
    output ubep_pkg::ubep_link_s link_o
);
    logic ack_due;
    logic [2:0] tok_ep;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            link_o <= '0;
            ack_due <= 1'b0;
            tok_ep <= 3'h0;
        end else begin
            link_o.in_token <= go_i && !out_i;
            link_o.out_done <= go_i && out_i;
            link_o.bad <= go_i && bad_i;
            // Ack only a data answer, one idle cycle after it
            ack_due <= ack_en_i && resp_i.send && (resp_i.pid == `UBEP_PID_DATA0 ||
                resp_i.pid == `UBEP_PID_DATA1);
            link_o.host_ack <= ack_due;
            tok_ep <= go_i ? ep_i : tok_ep;
            // Idle endpoint field keeps changing, never a stale copy
            link_o.ep <= go_i ? ep_i : (ack_due ? tok_ep : ~link_o.ep);
        end
    end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the bulk endpoint block with a reference model.
// Assumes the host model on the link and register access on the plain port.
`timescale 1ns/10ps
`include "ubep_consts.svh"
module tb;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic usb_rst = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic is_out = 1'b0;
    logic bad = 1'b0;
    logic ack_en = 1'b0;
    logic [2:0] ep = 3'h0;
    logic [7:0] rdata;
    logic irq;
    ubep_pkg::ubep_link_s link;
    ubep_pkg::ubep_resp_s resp;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_004f;
    int inq[6][$];
    int oarm[6];
    logic [5:0] istl = '0, ostl = '0, itog = '0, otog = '0, iirq = '0, oirq = '0;
    logic [7:0] ival = '0, oval = '0, iien = '0, oien = '0;
    logic pair = 1'b0;

    ubep_bulk_endpoints uut (.mclk_i(mclk_i), .reset_i(reset_i), .usb_reset_i(usb_rst),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .link_i(link), .resp_o(resp), .irq_o(irq));
    ubep_host_model host (.mclk_i(mclk_i), .reset_i(reset_i), .go_i(go), .out_i(is_out),
        .bad_i(bad), .ack_en_i(ack_en), .ep_i(ep), .resp_i(resp), .link_o(link));

    always #12.5 mclk_i = ~mclk_i;
    // Generous ceiling: the whole sequence needs well under 15000 cycles
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors = errors + 1;
            test_done();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int lim(input int e);
        return (pair && e == 2) ? 2 : 1;
    endfunction
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic chk_resp(input logic [16:0] exp, input logic [16:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        @(negedge mclk_i);
        d = rdata;
    endtask
    task automatic fw_bc(input logic o, input int e, input logic [7:0] n);
        wr_reg(6'((o ? `UBEP_ADR_OUT_BC : `UBEP_ADR_IN_BC) + e), n);
        if (o && oarm[e] < lim(e)) oarm[e]++;
        if (!o && inq[e].size() < lim(e)) inq[e].push_back(n);
    endtask
    task automatic fw_cs(input logic o, input int e, input logic [7:0] v);
        wr_reg(6'((o ? `UBEP_ADR_OUT_CS : `UBEP_ADR_IN_CS) + e), v);
        if (o) ostl[e] = v[0];
        else istl[e] = v[0];
        if (pair && e == 2 && v[1]) begin
            if (o) oarm[2] = 0;
            else inq[2].delete();
        end
    endtask
    task automatic chk_cs(input logic o, input int e);
        logic [7:0] d;
        logic b;
        rd_reg(6'((o ? `UBEP_ADR_OUT_CS : `UBEP_ADR_IN_CS) + e), d);
        b = o ? (oarm[e] == lim(e)) : (inq[e].size() == lim(e));
        chk8({6'h00, b, o ? ostl[e] : istl[e]}, d);
    endtask
    task automatic irq_cfg(input logic o, input logic [7:0] ien, input logic [7:0] clr);
        logic [7:0] d;
        wr_reg(o ? `UBEP_ADR_OUT_IEN : `UBEP_ADR_IN_IEN, ien);
        wr_reg(o ? `UBEP_ADR_OUT_IRQ : `UBEP_ADR_IN_IRQ, clr);
        if (o) begin
            oien = ien;
            oirq &= ~clr[5:0];
        end else begin
            iien = ien;
            iirq &= ~clr[5:0];
        end
        rd_reg(o ? `UBEP_ADR_OUT_IRQ : `UBEP_ADR_IN_IRQ, d);
        chk8({2'b00, o ? oirq : iirq}, d);
        chk8({7'h00, |((iirq & iien[5:0]) | (oirq & oien[5:0]))}, {7'h00, irq});
    endtask
    task automatic tog_set(input logic o, input logic [2:0] e, input logic v);
        logic [7:0] d;
        wr_reg(`UBEP_ADR_TOGGLE, {3'b000, !o, 1'b0, e});
        wr_reg(`UBEP_ADR_TOGGLE, {1'b0, v, !v, !o, 1'b0, e});
        if (o) otog[e] = v;
        else itog[e] = v;
        rd_reg(`UBEP_ADR_TOG_STATE, d);
        chk8({7'h00, v}, {7'h00, d[0]});
    endtask
    task automatic tok(input logic o, input logic [2:0] e, input logic b, input logic a);
        logic [16:0] got;
        logic [16:0] exp;
        logic dat;
        int m;
        got = '0;
        exp = '0;
        dat = 1'b0;
        m = (e >= 1 && e <= 5) ? e : 0;
        @(posedge mclk_i);
        go <= 1'b1;
        is_out <= o;
        ep <= e;
        bad <= b;
        ack_en <= a;
        @(posedge mclk_i);
        go <= 1'b0;
        repeat (8) begin
            @(negedge mclk_i);
            if (resp.send === 1'b1) got = resp;
        end
        if (!b && m != 0 && (o ? oval[m] : ival[m])) begin
            if (o ? ostl[m] : istl[m]) begin
                exp = {1'b1, `UBEP_PID_STALL, 8'h00, e, 1'b0};
            end else if (o && oarm[m] > 0) begin
                exp = {1'b1, `UBEP_PID_ACK, 8'h00, e, 1'b0};
                oarm[m]--;
                oirq[m] = 1'b1;
                otog[m] = !otog[m];
            end else if (!o && inq[m].size() > 0) begin
                dat = 1'b1;
                exp = {1'b1, itog[m] ? `UBEP_PID_DATA1 : `UBEP_PID_DATA0, 8'(inq[m][0]), e, 1'b0};
                if (a) begin
                    void'(inq[m].pop_front());
                    iirq[m] = 1'b1;
                    itog[m] = !itog[m];
                end
            end else begin
                exp = {1'b1, `UBEP_PID_NAK, 8'h00, e, 1'b0};
            end
        end
        // Buffer choice and paired physical endpoint are the design's own
        got[0] = 1'b0;
        if (!dat) got[11:4] = 8'h00;
        if (pair && m == 2 && got[16]) got[3:1] = e;
        chk_resp(exp, got);
        chk8({7'h00, |((iirq & iien[5:0]) | (oirq & oien[5:0]))}, {7'h00, irq});
    endtask

    initial begin
        int k;
        int n;
        logic [31:0] r;
        logic [7:0] d;
        logic [2:0] e;
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        for (k = 0; k < 9; k++) begin
            rd_reg(6'(k), d);
            chk8(8'h00, d);
        end
        rd_reg(6'h3f, d);
        chk8(8'h00, d);
        wr_reg(6'h3f, 8'hff);
        fw_bc(0, 1, 8'h05);
        tok(0, 1, 0, 1);
        wr_reg(`UBEP_ADR_IN_VALID, 8'h3e);
        wr_reg(`UBEP_ADR_OUT_VALID, 8'h3e);
        ival = 8'h3e;
        oval = 8'h3e;
        rd_reg(`UBEP_ADR_OUT_VALID, d);
        chk8(8'h3e, d);
        irq_cfg(0, 8'h3e, 8'h00);
        irq_cfg(1, 8'h3e, 8'h00);
        tok(0, 0, 0, 1);
        tok(1, 7, 0, 1);
        for (n = 0; n < 350; n++) begin
            r = xs();
            e = 3'(1 + r[15:8] % 5);
            case (r[2:0])
                3'd0: if (inq[e].size() == 0) fw_bc(0, e, r[23:16]);
                3'd1: fw_bc(1, e, r[23:16]);
                3'd2: fw_cs(r[3], e, {7'h00, r[4] & r[5]});
                3'd3, 3'd4: tok(0, e, r[12:11] == 2'b00, r[13] | r[14]);
                3'd5, 3'd6: tok(1, e, r[12:11] == 2'b00, 1'b0);
                default: begin
                    irq_cfg(r[3], r[31:24], r[23:16]);
                    tog_set(r[3], e, r[10]);
                end
            endcase
            chk_cs(r[3], e);
        end
        @(posedge mclk_i);
        usb_rst <= 1'b1;
        @(posedge mclk_i);
        usb_rst <= 1'b0;
        for (k = 0; k < 6; k++) begin
            inq[k].delete();
            oarm[k] = 0;
        end
        itog = '0;
        otog = '0;
        fw_cs(0, 2, 8'h00);
        fw_cs(1, 2, 8'h00);
        wr_reg(`UBEP_ADR_PAIRING, 8'h01);
        pair = 1'b1;
        tog_set(0, 3'd2, 1'b0);
        fw_bc(0, 2, 8'h11);
        chk_cs(0, 2);
        fw_bc(0, 2, 8'h22);
        chk_cs(0, 2);
        irq_cfg(0, 8'h3e, 8'h3f);
        tok(0, 2, 0, 1);
        chk_cs(0, 2);
        tok(0, 2, 0, 1);
        fw_bc(0, 2, 8'h33);
        tok(0, 2, 0, 1);
        fw_bc(0, 2, 8'h44);
        fw_bc(0, 2, 8'h55);
        fw_cs(0, 2, 8'h02);
        tok(0, 2, 0, 1);
        fw_bc(1, 2, 8'h40);
        fw_bc(1, 2, 8'h40);
        chk_cs(1, 2);
        irq_cfg(1, 8'h3e, 8'h3f);
        tok(1, 2, 0, 0);
        chk_cs(1, 2);
        tok(1, 2, 0, 0);
        tok(1, 2, 0, 0);
        fw_bc(1, 2, 8'h40);
        fw_bc(1, 2, 8'h40);
        fw_cs(1, 2, 8'h02);
        tok(1, 2, 0, 0);
        test_done();
    end
endmodule
